// *** rtl/ssw_regbank.sv ***
/*
  register bank of a serially controlled octal switch: switch state,
  error checking config, error flags, burst control and soft reset key.
  assumes: clk at 25 MHz; sclk_link, cs_n and sdi come from the host pins.
*/
// Summary of operation
// RULE1: eight-bit register drives eight switches
// RULE2: bit n closes switch n+1 when one
// RULE3: error config register, reset enables address, count
// RULE4: config bit 2 enables bad address check
// RULE5: count check, plain mode: exactly 16 clocks
// RULE6: count check, checksum mode: exactly 24 clocks
// RULE7: burst without checksum: clocks multiple of 16
// RULE8: burst with checksum: clocks multiple of 24
// RULE9: config bit 1 enables clock count check
// RULE10: host writes zero to config bits 7..3
// RULE11: config bit 0 enables checksum, 24-bit frames
// RULE12: burst bit allows several commands per frame
// RULE13: key 0xA3 then 0x05 restores defaults
// RULE14: command 0x6CA9 clears the error flags
// RULE15: disabled check never raises its flag
// RULE16: reserved bits always read as zero
`timescale 1ns/1ps
`default_nettype none

module ssw_regbank (
  // system
  input wire logic clk,
  input wire logic arst_n,
  // serial link
  input wire logic sclk_link,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // switch drive
  output logic [7:0] switch_close
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // registers and link slice
  // ----------------------------------------------------------------
  logic [7:0] switch_state_q;
  logic [7:0] error_check_config_q;
  logic [7:0] error_flag_status_q;
  logic [7:0] burst_control_q;
  logic [7:0] soft_reset_key_q;
  ssw_pkg::ssw_key_t key_q;
  ssw_pkg::ssw_key_t key_d;
  ssw_pkg::ssw_regs_t regs;
  ssw_pkg::ssw_word_t word;
  ssw_pkg::ssw_tally_t tally;
  logic word_tgl;

  wire logic crc_en = error_check_config_q[ssw_pkg::CFG_CRC_BIT]; // RULE11
  wire logic sclk_en = error_check_config_q[ssw_pkg::CFG_SCLK_BIT]; // RULE9
  wire logic rw_en = error_check_config_q[ssw_pkg::CFG_RW_BIT]; // RULE4
  wire logic burst_on = burst_control_q[ssw_pkg::BURST_BIT]; // RULE12

  assign regs.sw = switch_state_q;
  assign regs.cfg = error_check_config_q;
  assign regs.flags = error_flag_status_q;
  assign regs.burst = burst_control_q;
  assign regs.key = soft_reset_key_q;

  ssw_spi_link u_link (
    .sclk_link(sclk_link),
    .cs_n(cs_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .rst_n(rst_n),
    .crc_en(crc_en),
    .burst_on(burst_on),
    .regs(regs),
    .word_q(word),
    .word_tgl_q(word_tgl),
    .tally_q(tally)
  );

  // ----------------------------------------------------------------
  // crossings: chip select level and word toggle, two flops each
  // ----------------------------------------------------------------
  logic cs_meta_q;
  logic cs_sync_q;
  logic cs_prev_q;
  logic tgl_meta_q;
  logic tgl_sync_q;
  logic tgl_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_prev_q <= 1'b0;
    end else begin
      cs_meta_q <= cs_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      tgl_meta_q <= word_tgl;
      tgl_sync_q <= tgl_meta_q;
      tgl_prev_q <= tgl_sync_q;
    end
  end

  // word is held still by the link while word_pulse is seen, tally while frame_end is seen
  wire logic frame_end = cs_sync_q & ~cs_prev_q;
  wire logic word_pulse = tgl_sync_q ^ tgl_prev_q;
  wire logic frame_start = ~cs_sync_q & cs_prev_q;

  // ----------------------------------------------------------------
  // frame mode, taken when a frame opens
  // ----------------------------------------------------------------
  // a word that changes checksum or burst is still counted in its own mode
  logic frame_crc_q;
  logic frame_burst_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_crc_q <= ssw_pkg::CFG_RST[ssw_pkg::CFG_CRC_BIT];
      frame_burst_q <= ssw_pkg::BURST_RST[ssw_pkg::BURST_BIT];
    end else if (frame_start) begin
      frame_crc_q <= crc_en; // RULE11
      frame_burst_q <= burst_on; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire logic [15:0] cmd = word.cmd;
  wire logic is_read = cmd[ssw_pkg::CMD_RW_BIT];
  wire logic [6:0] addr = cmd[ssw_pkg::CMD_ADDR_HI:ssw_pkg::CMD_ADDR_LO];
  wire logic [7:0] wdata = cmd[ssw_pkg::CMD_DATA_HI:0];
  wire logic crc_bad = crc_en && (ssw_pkg::ssw_crc8(cmd) != word.crc); // RULE11
  wire logic is_clear = (cmd == ssw_pkg::CLEAR_CMD); // RULE14
  wire logic addr_bad = !ssw_pkg::ssw_addr_known(addr) || (!is_read && addr == ssw_pkg::ADDR_FLAG);
  wire logic exec = word_pulse & ~crc_bad;
  wire logic do_clear = exec & is_clear; // RULE14
  wire logic wr_ok = exec & ~is_clear & ~is_read & ~addr_bad;
  wire logic rw_err = exec & ~is_clear & addr_bad & rw_en; // RULE4 RULE15
  wire logic crc_err = word_pulse & crc_bad; // RULE15
  wire logic wr_switch = wr_ok && addr == ssw_pkg::ADDR_SWITCH;
  wire logic wr_cfg = wr_ok && addr == ssw_pkg::ADDR_CFG;
  wire logic wr_burst = wr_ok && addr == ssw_pkg::ADDR_BURST;
  wire logic wr_key = wr_ok && addr == ssw_pkg::ADDR_KEY;
  wire logic key_arm = wr_key && wdata == ssw_pkg::SOFT_KEY_ARM;
  wire logic soft_go = wr_key && wdata == ssw_pkg::SOFT_KEY_FIRE && key_q == ssw_pkg::SSW_KEY_ARMED; // RULE13

  // ----------------------------------------------------------------
  // clock count check at frame end; an empty frame is checked again on the held tally of the last frame
  // ----------------------------------------------------------------
  wire logic [4:0] word_len = frame_crc_q ? ssw_pkg::LEN_CRC : ssw_pkg::LEN_PLAIN;
  wire logic count_some = (tally.count != 16'h0000);
  wire logic count_exact = (tally.count == 16'(word_len)); // RULE5 RULE6
  wire logic count_whole = (tally.phase == 5'h00); // RULE7 RULE8
  wire logic count_ok = frame_burst_q ? count_whole : count_exact;
  wire logic sclk_err = frame_end & sclk_en & count_some & ~count_ok; // RULE9 RULE15

  wire logic [7:0] flag_set = (8'(crc_err) << ssw_pkg::FLAG_CRC_BIT) | (8'(sclk_err) << ssw_pkg::FLAG_SCLK_BIT)
    | (8'(rw_err) << ssw_pkg::FLAG_RW_BIT);
  // a new error in the clearing cycle still lands
  wire logic [7:0] flags_base = (do_clear || soft_go) ? ssw_pkg::FLAG_RST : error_flag_status_q;
  wire logic [7:0] flags_d = (flags_base | flag_set) & ssw_pkg::FLAG_MASK; // RULE16

  // ----------------------------------------------------------------
  // soft reset key sequence
  // ----------------------------------------------------------------
  always_comb begin
    key_d = key_q;
    case (key_q)
      ssw_pkg::SSW_KEY_IDLE: begin
        if (word_pulse && key_arm) key_d = ssw_pkg::SSW_KEY_ARMED; // RULE13
      end
      ssw_pkg::SSW_KEY_ARMED: begin
        if (word_pulse) key_d = key_arm ? ssw_pkg::SSW_KEY_ARMED : ssw_pkg::SSW_KEY_IDLE;
      end
      default: key_d = ssw_pkg::SSW_KEY_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_state_q <= ssw_pkg::SWITCH_RST;
      error_check_config_q <= ssw_pkg::CFG_RST;
      burst_control_q <= ssw_pkg::BURST_RST;
      soft_reset_key_q <= ssw_pkg::KEY_RST;
      key_q <= ssw_pkg::SSW_KEY_IDLE;
    end else if (soft_go) begin // RULE13
      switch_state_q <= ssw_pkg::SWITCH_RST;
      error_check_config_q <= ssw_pkg::CFG_RST; // RULE3
      burst_control_q <= ssw_pkg::BURST_RST;
      soft_reset_key_q <= ssw_pkg::KEY_RST;
      key_q <= ssw_pkg::SSW_KEY_IDLE;
    end else begin
      if (wr_switch) switch_state_q <= wdata; // RULE1
      if (wr_cfg) error_check_config_q <= wdata & ssw_pkg::CFG_MASK; // RULE3 RULE16
      if (wr_burst) burst_control_q <= wdata & ssw_pkg::BURST_MASK; // RULE12 RULE16
      if (wr_key) soft_reset_key_q <= wdata;
      key_q <= key_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) error_flag_status_q <= ssw_pkg::FLAG_RST;
    else error_flag_status_q <= flags_d; // RULE14
  end

  assign switch_close = switch_state_q; // RULE2

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sw_write_a: assert property (wr_switch && !soft_go |=> switch_state_q == $past(wdata)) // RULE1
    else $error("switch register missed a write");

  sw_pin_map_a: assert property (wr_switch |=> switch_close[0] == $past(wdata[0]) && switch_close[7] == $past(wdata[7])) // RULE2
    else $error("switch bit order wrong");

  cfg_default_a: assert property (soft_go |=> error_check_config_q == ssw_pkg::CFG_RST) // RULE3
    else $error("config not back at default");

  rw_flag_set_a: assert property (exec && !is_clear && addr_bad && rw_en |=> error_flag_status_q[ssw_pkg::FLAG_RW_BIT]) // RULE4
    else $error("bad address not flagged");

  len_plain_a: assert property (frame_end && sclk_en && !frame_crc_q && !frame_burst_q && count_some
    && tally.count != 16'(ssw_pkg::LEN_PLAIN) |=> error_flag_status_q[ssw_pkg::FLAG_SCLK_BIT]) // RULE5
    else $error("wrong 16-clock frame not flagged");

  len_crc_a: assert property (frame_end && sclk_en && frame_crc_q && !frame_burst_q && count_some
    && tally.count != 16'(ssw_pkg::LEN_CRC) |=> error_flag_status_q[ssw_pkg::FLAG_SCLK_BIT]) // RULE6
    else $error("wrong 24-clock frame not flagged");

  burst_mult16_a: assert property (frame_end && sclk_en && !frame_crc_q && frame_burst_q
    && tally.count[3:0] != 4'h0 |=> error_flag_status_q[ssw_pkg::FLAG_SCLK_BIT]) // RULE7
    else $error("burst frame not multiple of 16 unflagged");

  burst_mult24_a: assert property (frame_end && sclk_en && frame_crc_q && frame_burst_q && count_some
    && (tally.count % 16'h0018) == 16'h0000 && !do_clear |=> !$rose(error_flag_status_q[ssw_pkg::FLAG_SCLK_BIT])) // RULE8
    else $error("good 24-multiple burst frame flagged");

  sclk_gate_a: assert property ($rose(error_flag_status_q[ssw_pkg::FLAG_SCLK_BIT]) |-> $past(sclk_en)) // RULE9
    else $error("count flag raised while disabled");

  crc_flag_a: assert property (word_pulse && crc_en && ssw_pkg::ssw_crc8(cmd) != word.crc
    |=> error_flag_status_q[ssw_pkg::FLAG_CRC_BIT] && $stable(switch_state_q)) // RULE11
    else $error("bad checksum not flagged or executed");

  soft_reset_a: assert property (soft_go |=> switch_state_q == ssw_pkg::SWITCH_RST
    && burst_control_q == ssw_pkg::BURST_RST && key_q == ssw_pkg::SSW_KEY_IDLE) // RULE13
    else $error("soft reset incomplete");

  flag_clear_a: assert property (do_clear && !frame_end |=> error_flag_status_q == ssw_pkg::FLAG_RST) // RULE14
    else $error("clear command left flags");

  rw_gate_a: assert property ($rose(error_flag_status_q[ssw_pkg::FLAG_RW_BIT]) |-> $past(rw_en)) // RULE15
    else $error("address flag raised while disabled");

  crc_gate_a: assert property ($rose(error_flag_status_q[ssw_pkg::FLAG_CRC_BIT]) |-> $past(crc_en)) // RULE15
    else $error("checksum flag raised while disabled");

  flag_sticky_a: assert property (!do_clear && !soft_go
    |=> (error_flag_status_q & $past(error_flag_status_q)) == $past(error_flag_status_q)) // RULE14
    else $error("error flag dropped without a clear");

  key_cancel_a: assert property (key_q == ssw_pkg::SSW_KEY_ARMED && word_pulse && !key_arm && !soft_go
    |=> key_q == ssw_pkg::SSW_KEY_IDLE) // RULE13
    else $error("soft reset arm not cancelled");

  bad_addr_hold_a: assert property (exec && addr_bad |=> $stable(switch_state_q) && $stable(burst_control_q)
    && $stable(error_check_config_q)) // RULE4
    else $error("write to bad address landed");

  reserved_zero_a: assert property ((error_check_config_q & ~ssw_pkg::CFG_MASK) == 8'h00
    && (burst_control_q & ~ssw_pkg::BURST_MASK) == 8'h00 && (error_flag_status_q & ~ssw_pkg::FLAG_MASK) == 8'h00) // RULE16
    else $error("reserved bits not zero");

endmodule

`default_nettype wire

// *** shared/ssw_pkg.sv ***
/*
  constants, types and helper functions of the serial switch register bank.
  assumes: shared by the bank top and its serial link slice; no state here.
*/
`default_nettype none

package ssw_pkg;

  // ----------------------------------------------------------------
  // register offsets, reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_SWITCH = 7'h01;
  localparam logic [6:0] ADDR_CFG = 7'h02;
  localparam logic [6:0] ADDR_FLAG = 7'h03;
  localparam logic [6:0] ADDR_BURST = 7'h05;
  localparam logic [6:0] ADDR_KEY = 7'h0B;

  localparam logic [7:0] SWITCH_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h06;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] BURST_RST = 8'h00;
  localparam logic [7:0] KEY_RST = 8'h00;

  localparam logic [7:0] CFG_MASK = 8'h07;
  localparam logic [7:0] FLAG_MASK = 8'h07;
  localparam logic [7:0] BURST_MASK = 8'h01;

  localparam int unsigned CFG_CRC_BIT = 0;
  localparam int unsigned CFG_SCLK_BIT = 1;
  localparam int unsigned CFG_RW_BIT = 2;
  localparam int unsigned FLAG_CRC_BIT = 0;
  localparam int unsigned FLAG_SCLK_BIT = 1;
  localparam int unsigned FLAG_RW_BIT = 2;
  localparam int unsigned BURST_BIT = 0;

  // ----------------------------------------------------------------
  // command word layout and special values
  // ----------------------------------------------------------------
  localparam int unsigned CMD_RW_BIT = 15;
  localparam int unsigned CMD_ADDR_HI = 14;
  localparam int unsigned CMD_ADDR_LO = 8;
  localparam int unsigned CMD_DATA_HI = 7;
  localparam logic [15:0] CLEAR_CMD = 16'h6CA9;
  localparam logic [7:0] SOFT_KEY_ARM = 8'hA3;
  localparam logic [7:0] SOFT_KEY_FIRE = 8'h05;
  localparam logic [7:0] ALIGN_BYTE = 8'h25;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // ----------------------------------------------------------------
  // frame lengths and in-frame bit positions in serial clock cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] LEN_PLAIN = 5'h10;
  localparam logic [4:0] LEN_CRC = 5'h18;
  localparam logic [4:0] ADDR_EDGE = 5'h08;
  localparam logic [4:0] RESP_MSB = 5'h0F;

  typedef enum logic {SSW_KEY_IDLE, SSW_KEY_ARMED} ssw_key_t;

  typedef struct packed {
    logic [7:0] sw;
    logic [7:0] cfg;
    logic [7:0] flags;
    logic [7:0] burst;
    logic [7:0] key;
  } ssw_regs_t;

  typedef struct packed {
    logic [15:0] cmd;
    logic [7:0] crc;
  } ssw_word_t;

  typedef struct packed {
    logic [15:0] count;
    logic [4:0] phase;
  } ssw_tally_t;

  function automatic logic ssw_addr_known(input logic [6:0] a);
    return (a == ADDR_SWITCH) || (a == ADDR_CFG) || (a == ADDR_FLAG) || (a == ADDR_BURST) || (a == ADDR_KEY);
  endfunction

  function automatic logic [7:0] ssw_reg_read(input ssw_regs_t r, input logic [6:0] a);
    if (a == ADDR_SWITCH) return r.sw;
    else if (a == ADDR_CFG) return r.cfg;
    else if (a == ADDR_FLAG) return r.flags;
    else if (a == ADDR_BURST) return r.burst;
    else if (a == ADDR_KEY) return r.key;
    else return 8'h00;
  endfunction

  // msb-first crc over the 16-bit command
  function automatic logic [7:0] ssw_crc8(input logic [15:0] d);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

endpackage

`default_nettype wire

// *** rtl/ssw_spi_link.sv ***
/*
  serial link slice on the link clock: shifts commands in, answers on sdo.
  assumes: the link clock runs only while cs_n is low; config and register
  images from the system clock change only between commands.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_spi_link (
  // link pins
  input wire logic sclk_link,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // from the system domain
  input wire logic rst_n,
  input wire logic crc_en,
  input wire logic burst_on,
  input wire ssw_pkg::ssw_regs_t regs,
  // to the system domain
  output ssw_pkg::ssw_word_t word_q,
  output logic word_tgl_q,
  output ssw_pkg::ssw_tally_t tally_q
);

  logic fresh_q;
  logic first_done_q;
  logic [23:0] sreg_q;
  logic [6:0] addr_q;
  logic sdo_q;

  wire logic [23:0] sreg_d = {sreg_q[22:0], sdi};
  wire logic [4:0] phase_cur = fresh_q ? 5'h00 : tally_q.phase;
  wire logic [15:0] count_cur = fresh_q ? 16'h0000 : tally_q.count;
  wire logic first_cur = fresh_q ? 1'b0 : first_done_q;
  wire logic [4:0] phase_inc = phase_cur + 5'h01;
  wire logic [4:0] word_len = crc_en ? ssw_pkg::LEN_CRC : ssw_pkg::LEN_PLAIN;
  wire logic boundary = (phase_inc == word_len);
  wire logic accept = boundary && (burst_on || !first_cur);
  wire logic [15:0] resp = {ssw_pkg::ALIGN_BYTE, ssw_pkg::ssw_reg_read(regs, addr_q)};
  wire logic [3:0] resp_idx = 4'(ssw_pkg::RESP_MSB - tally_q.phase);
  wire logic resp_bit = (tally_q.phase <= ssw_pkg::RESP_MSB) ? resp[resp_idx] : 1'b0;

  // ----------------------------------------------------------------
  // frame start marker, cleared by the first edge of a frame
  // ----------------------------------------------------------------
  always_ff @(posedge sclk_link or posedge cs_n) begin
    if (cs_n) fresh_q <= 1'b1;
    else fresh_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // shifter, counters and word hand-off; tally holds after the frame
  // ----------------------------------------------------------------
  always_ff @(posedge sclk_link or negedge rst_n) begin
    if (!rst_n) begin
      sreg_q <= 24'h00_0000;
      tally_q <= '0;
      first_done_q <= 1'b0;
      word_q <= '0;
      word_tgl_q <= 1'b0;
      addr_q <= 7'h00;
    end else begin
      sreg_q <= sreg_d;
      tally_q.count <= count_cur + 16'h0001;
      tally_q.phase <= boundary ? 5'h00 : phase_inc;
      first_done_q <= first_cur | boundary;
      if (phase_inc == ssw_pkg::ADDR_EDGE) addr_q <= sreg_d[6:0];
      if (accept) begin // RULE12
        word_q.cmd <= crc_en ? sreg_d[23:8] : sreg_d[15:0]; // RULE11
        word_q.crc <= sreg_d[7:0];
        word_tgl_q <= ~word_tgl_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // answer: alignment byte then read data, out on the falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge sclk_link or posedge cs_n) begin
    if (cs_n) sdo_q <= ssw_pkg::ALIGN_BYTE[7];
    else sdo_q <= resp_bit;
  end

  assign sdo = sdo_q;
  assign sdo_oe = ~cs_n;

  single_word_a: assert property (@(posedge sclk_link) disable iff (!rst_n || cs_n)
    (boundary && first_cur && !burst_on) |=> $stable(word_tgl_q)) // RULE12
    else $error("second command taken with burst off");

endmodule

`default_nettype wire

// *** dv/ssw_host_model.sv ***
/*
  serial host model: drives framed transfers on the link pins of the bank.
  assumes: mode 0 timing, link clock of 125 ns that stands low between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_host_model (
  // link pins
  output logic sclk_link,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  localparam realtime HALF = 62.5;

  initial begin
    sclk_link = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b1;
  end

  // ----------------------------------------------------------------
  // one frame of n clocks, bits[n-1] first; several words per frame allowed
  // ----------------------------------------------------------------
  task automatic frame(input logic [47:0] bits, input int n, output logic [47:0] rsp);
    rsp = '0;
    cs_n = 1'b0;
    sdi = bits[n-1];
    for (int i = n - 1; i >= 0; i--) begin
      #HALF;
      sclk_link = 1'b1;
      rsp = {rsp[46:0], sdo_oe & sdo};
      #HALF;
      sclk_link = 1'b0;
      if (i > 0) begin
        sdi = bits[i-1];
      end
    end
    #HALF;
    cs_n = 1'b1;
    // released data line shows the inverse of its last value
    sdi = ~sdi;
  endtask
endmodule

`default_nettype wire

// *** dv/tb_ssw_regbank.sv ***
/*
  self-checking bench of the serial switch register bank.
  assumes: the host model drives the link; system clock 25 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_ssw_regbank;
  logic clk, arst_n, sclk_link, cs_n, sdi, sdo, sdo_oe;
  logic [7:0] switch_close;
  logic crc_mode;
  logic [47:0] last_rsp;
  int err_total, checked;

  ssw_regbank u_dut (.clk(clk), .arst_n(arst_n), .sclk_link(sclk_link), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .switch_close(switch_close));
  ssw_host_model u_host (.sclk_link(sclk_link), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic raw(input logic [47:0] b, input int n);
    #7;
    u_host.frame(b, n, last_rsp);
    repeat (8) @(negedge clk);
  endtask

  task automatic send(input logic [15:0] w, input int n);
    logic [47:0] b;
    int len;
    len = crc_mode ? 24 : 16;
    b = crc_mode ? {24'h00_0000, w, crc8(w)} : {32'h0000_0000, w};
    b = (n >= len) ? b << (n - len) : b >> (len - n);
    raw(b, n);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    send({1'b0, a, d}, crc_mode ? 24 : 16);
  endtask

  task automatic clear_flags;
    send(16'h6ca9, crc_mode ? 24 : 16);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    send({1'b1, a, 8'h00}, crc_mode ? 24 : 16);
    chk(crc_mode ? last_rsp[15:8] : last_rsp[7:0], exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(switch_close, 8'h00);
    rd_chk(ssw_pkg::ADDR_CFG, 8'h06);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h00);
    rd_chk(ssw_pkg::ADDR_BURST, 8'h00);
    rd_chk(ssw_pkg::ADDR_KEY, 8'h00);
    chk(last_rsp[15:8], 8'h25);
    rd_chk(ssw_pkg::ADDR_SWITCH, 8'h00);
    $display("reset values done");
  endtask

  task automatic t_switch;
    for (int i = 0; i < 8; i++) begin
      wr(ssw_pkg::ADDR_SWITCH, 8'h01 << i);
      chk(switch_close, 8'h01 << i);
    end
    wr(ssw_pkg::ADDR_SWITCH, 8'h5a);
    rd_chk(ssw_pkg::ADDR_SWITCH, 8'h5a);
    chk(switch_close, 8'h5a);
    $display("switch map done");
  endtask

  task automatic t_addr;
    wr(7'h04, 8'hff);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h04);
    rd_chk(ssw_pkg::ADDR_SWITCH, 8'h5a);
    clear_flags();
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h00);
    wr(ssw_pkg::ADDR_FLAG, 8'h07);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h04);
    clear_flags();
    wr(ssw_pkg::ADDR_CFG, 8'h02);
    wr(7'h04, 8'h00);
    rd_chk(7'h7f, 8'h00);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h00);
    wr(ssw_pkg::ADDR_CFG, 8'hfa);
    rd_chk(ssw_pkg::ADDR_CFG, 8'h02);
    wr(ssw_pkg::ADDR_CFG, 8'h06);
    $display("address check done");
  endtask

  task automatic t_count;
    send({1'b0, ssw_pkg::ADDR_SWITCH, 8'h33}, 17);
    chk(switch_close, 8'h33);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h02);
    clear_flags();
    send({1'b0, ssw_pkg::ADDR_SWITCH, 8'hcc}, 15);
    chk(switch_close, 8'h33);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h02);
    clear_flags();
    send({1'b0, ssw_pkg::ADDR_SWITCH, 8'h44}, 33);
    chk(switch_close, 8'h44);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h02);
    clear_flags();
    wr(ssw_pkg::ADDR_CFG, 8'h04);
    send({1'b0, ssw_pkg::ADDR_SWITCH, 8'h3c}, 17);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h00);
    wr(ssw_pkg::ADDR_CFG, 8'h06);
    $display("clock count done");
  endtask

  task automatic t_crc;
    logic [15:0] w;
    wr(ssw_pkg::ADDR_CFG, 8'h07);
    crc_mode = 1'b1;
    wr(ssw_pkg::ADDR_SWITCH, 8'ha5);
    chk(switch_close, 8'ha5);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h00);
    w = {1'b0, ssw_pkg::ADDR_SWITCH, 8'h0f};
    raw({24'h00_0000, w, crc8(w) ^ 8'h01}, 24);
    chk(switch_close, 8'ha5);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h01);
    clear_flags();
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h00);
    send(w, 16);
    chk(switch_close, 8'ha5);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h02);
    clear_flags();
    wr(ssw_pkg::ADDR_BURST, 8'h01);
    raw({w, crc8(w), 16'h0111, crc8(16'h0111)}, 48);
    chk(switch_close, 8'h11);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h00);
    wr(ssw_pkg::ADDR_CFG, 8'h06);
    crc_mode = 1'b0;
    $display("checksum done");
  endtask

  task automatic t_burst;
    raw({16'h0000, 16'h0144, 16'h0155}, 32);
    chk(switch_close, 8'h55);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h00);
    raw({16'h0144, 16'h0166, 16'h0000} >> 8, 40);
    chk(switch_close, 8'h66);
    rd_chk(ssw_pkg::ADDR_FLAG, 8'h02);
    clear_flags();
    $display("burst done");
  endtask

  task automatic t_soft;
    wr(ssw_pkg::ADDR_SWITCH, 8'h77);
    wr(ssw_pkg::ADDR_KEY, 8'ha3);
    wr(ssw_pkg::ADDR_SWITCH, 8'h77);
    wr(ssw_pkg::ADDR_KEY, 8'h05);
    rd_chk(ssw_pkg::ADDR_BURST, 8'h01);
    wr(ssw_pkg::ADDR_KEY, 8'ha3);
    wr(ssw_pkg::ADDR_KEY, 8'h05);
    chk(switch_close, 8'h00);
    rd_chk(ssw_pkg::ADDR_BURST, 8'h00);
    rd_chk(ssw_pkg::ADDR_CFG, 8'h06);
    $display("soft reset done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    crc_mode = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_switch();
    t_addr();
    t_count();
    t_crc();
    t_burst();
    t_soft();
    tally_and_finish();
  end

  // about 70 frames of at most 6.4 us each fit well inside this span
  initial begin
    #1_000_000;
    err_total++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
